// file: hdl/hvr_ctrl.sv
// High-voltage supply set-point controller with Avalon-MM registers
//
// Contract
// - Turn-on target is the default level or the command's level argument.
// - A turn-on above the maximum level is rejected, setting unchanged.
// - No turn-on while the instrument is in the safe state.
// - No turn-on while any unmasked safety condition is active.
// - Target above set-point: raise by one step per step interval.
// - Target below set-point: load target at once.
// - Turn-off by command or safety trigger beats turn-on and ramp.
// - Step interval programmable in whole seconds, 1 to 255.
// - Fraction below 16 gives linear steps equal to the fraction.
// - Fraction 16 or more: step is difference*16/fraction, at least one.
// - Both supplies get the same level setting while both are on.
// - Configuration selects first, second or both; disabled supply stays off.
// - Sensor limit enabled and not dark: level limited to safe level.
// - Safety monitor may override the controller while a supply is active.
// - Each supply gets a level setting, an enable and an arm.
// - A supply is on only while its low-voltage supply is on.
// - Direct commands only in state_a, with same ramp and limit rules.
// - Safe-level limit is re-evaluated every cycle, without ramp delay.
`timescale 1ns/100ps
module hvr_ctrl
   import hvr_pkg::*;
(
   // Clock and reset
   input  wire logic              mclk_i,
   input  wire logic              nrst_i,
   // Avalon-MM slave
   input  wire logic [5:0]        avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   input  wire logic [3:0]        avs_byteenable_i,
   output logic      [31:0]       avs_readdata_o,
   output logic                   avs_waitrequest_o,
   // Instrument state and tick
   input  wire logic              sec_tick_i,
   input  wire logic              safe_state_i,
   input  wire logic              state_a_i,
   input  wire logic              auto_on_i,
   input  wire logic              auto_off_i,
   // Safety and sensing
   input  wire logic [SAFE_W-1:0] safety_cond_i,
   input  wire logic              safety_trip_i,
   input  wire logic              dark_i,
   input  wire logic [1:0]        low_voltage_supply_on_i,
   // Supplies and interrupt
   output hvr_supply_t            supply_a_o,
   output hvr_supply_t            supply_b_o,
   output logic                   irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   logic [LVL_W-1:0]  cmd_level_r;
   logic              use_cmd_level_r;
   logic [LVL_W-1:0]  default_target_level_r;
   logic [LVL_W-1:0]  max_allowed_level_r;
   logic [7:0]        ramp_step_interval_r;
   logic [7:0]        ramp_fraction_r;
   logic [1:0]        sup_sel_r;
   logic              sensor_limit_enable_r;
   logic [LVL_W-1:0]  safe_limit_level_r;
   logic [SAFE_W-1:0] safety_mask_r;
   logic [IRQ_W-1:0]  irq_stat_r;
   logic [IRQ_W-1:0]  irq_mask_r;
   hvr_state_t        state_r;
   logic [LVL_W-1:0]  requested_level_r;
   logic [LVL_W-1:0]  current_setpoint_r;
   logic [7:0]        sec_cnt_r;
   logic [LVL_W-1:0]  next_set;
   logic [LVL_W-1:0]  applied;
   logic [LVL_W-1:0]  target;
   logic [31:0]       rd_nxt;
   logic              acc;
   logic              wr_acc;
   logic              rd_acc;
   logic              cmd_on;
   logic              cmd_off;
   logic              turn_off;
   logic              on_req;
   logic              on_ok;
   logic              limited;
   logic              reached;
   logic [1:0]        lv_ok;
   logic [7:0]        interval;
   logic              step_due;
   logic [IRQ_W-1:0]  ev;

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake: one wait cycle, then accept
   assign acc    = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
   assign wr_acc = acc & avs_write_i;
   assign rd_acc = acc & avs_read_i;

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      end
   end

   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (avs_address_i)
         OFS_CMDLVL: begin
            rd_nxt[LVL_W-1:0]     = cmd_level_r;
            rd_nxt[CMDLVL_USE_BIT] = use_cmd_level_r;
         end
         OFS_DEFLVL:   rd_nxt[LVL_W-1:0] = default_target_level_r;
         OFS_MAXLVL:   rd_nxt[LVL_W-1:0] = max_allowed_level_r;
         OFS_INTERVAL: rd_nxt[7:0] = ramp_step_interval_r;
         OFS_FRAC:     rd_nxt[7:0] = ramp_fraction_r;
         OFS_CONFIG: begin
            rd_nxt[CFG_SUP_LSB+1:CFG_SUP_LSB] = sup_sel_r;
            rd_nxt[CFG_SENSOR_BIT]            = sensor_limit_enable_r;
         end
         OFS_SAFELVL:  rd_nxt[LVL_W-1:0] = safe_limit_level_r;
         OFS_SMASK:    rd_nxt[SAFE_W-1:0] = safety_mask_r;
         OFS_STATUS: begin
            rd_nxt[STAT_ACTIVE_BIT]                 = (state_r != HVR_OFF);
            rd_nxt[STAT_RAMP_BIT]                   = (state_r == HVR_RAMP);
            rd_nxt[STAT_LIMIT_BIT]                  = limited;
            rd_nxt[STAT_SET_LSB+LVL_W-1:STAT_SET_LSB] = current_setpoint_r;
            rd_nxt[STAT_REQ_LSB+LVL_W-1:STAT_REQ_LSB] = requested_level_r;
         end
         OFS_IRQSTAT:  rd_nxt[IRQ_W-1:0] = irq_stat_r;
         OFS_IRQMASK:  rd_nxt[IRQ_W-1:0] = irq_mask_r;
         default:      rd_nxt = 32'h0000_0000;
      endcase
   end

   // Data is latched in the wait cycle so it stands at the accept edge
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i & avs_waitrequest_o) begin
         avs_readdata_o <= rd_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Parameter registers, written only when all four byte lanes are enabled
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         cmd_level_r            <= '0;
         use_cmd_level_r        <= 1'b0;
         default_target_level_r <= RST_DEFLVL;
         max_allowed_level_r    <= RST_MAXLVL;
         ramp_step_interval_r   <= RST_INTERVAL;
         ramp_fraction_r        <= RST_FRAC;
         sup_sel_r              <= RST_SUP_EN;
         sensor_limit_enable_r  <= 1'b0;
         safe_limit_level_r     <= RST_SAFELVL;
         safety_mask_r          <= RST_SMASK;
         irq_mask_r             <= '0;
      end else if (wr_acc && avs_byteenable_i == 4'hf) begin
         case (avs_address_i)
            OFS_CMDLVL: begin
               cmd_level_r     <= avs_writedata_i[LVL_W-1:0];
               use_cmd_level_r <= avs_writedata_i[CMDLVL_USE_BIT];
            end
            OFS_DEFLVL:   default_target_level_r <= avs_writedata_i[LVL_W-1:0];
            OFS_MAXLVL:   max_allowed_level_r    <= avs_writedata_i[LVL_W-1:0];
            OFS_INTERVAL: begin
               // Zero would step on every tick, same as one; store it as one second
               ramp_step_interval_r <= (avs_writedata_i[7:0] == 8'h00) ?
                                       8'h01 : avs_writedata_i[7:0];
            end
            OFS_FRAC:     ramp_fraction_r <= avs_writedata_i[7:0];
            OFS_CONFIG: begin
               sup_sel_r             <= avs_writedata_i[CFG_SUP_LSB+1:CFG_SUP_LSB];
               sensor_limit_enable_r <= avs_writedata_i[CFG_SENSOR_BIT];
            end
            OFS_SAFELVL:  safe_limit_level_r <= avs_writedata_i[LVL_W-1:0];
            OFS_SMASK:    safety_mask_r      <= avs_writedata_i[SAFE_W-1:0];
            OFS_IRQMASK:  irq_mask_r         <= avs_writedata_i[IRQ_W-1:0];
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Turn-on and turn-off decisions
   assign cmd_on   = wr_acc & (avs_address_i == OFS_CTRL) &
                     avs_writedata_i[CTRL_ON_BIT] & state_a_i;
   assign cmd_off  = wr_acc & (avs_address_i == OFS_CTRL) &
                     avs_writedata_i[CTRL_OFF_BIT] & state_a_i;
   assign turn_off = cmd_off | auto_off_i | safety_trip_i;
   assign on_req   = cmd_on | auto_on_i;
   assign target   = (cmd_on & use_cmd_level_r) ? cmd_level_r :
                     default_target_level_r;
   assign lv_ok    = sup_sel_r & low_voltage_supply_on_i;
   assign on_ok    = (target <= max_allowed_level_r) &
                     ~safe_state_i &
                     ((safety_cond_i & ~safety_mask_r) == '0) &
                     (lv_ok != 2'b00);
   assign interval = ramp_step_interval_r;
   assign step_due = sec_tick_i & ((sec_cnt_r + 8'h01) >= interval);

   hvr_step_calc u_step (
      .req_i  (requested_level_r),
      .set_i  (current_setpoint_r),
      .frac_i (ramp_fraction_r),
      .next_o (next_set)
   );

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         state_r            <= HVR_OFF;
         requested_level_r  <= '0;
         current_setpoint_r <= '0;
         sec_cnt_r          <= 8'h00;
      end else if (turn_off) begin
         state_r            <= HVR_OFF;
         requested_level_r  <= '0;
         current_setpoint_r <= '0;
         sec_cnt_r          <= 8'h00;
      end else if (on_req && on_ok) begin
         requested_level_r <= target;
         sec_cnt_r         <= 8'h00;
         if (target < current_setpoint_r || state_r == HVR_OFF && target == '0) begin
            current_setpoint_r <= target;
            state_r            <= HVR_HOLD;
         end else begin
            state_r <= (target == current_setpoint_r) ? HVR_HOLD : HVR_RAMP;
         end
      end else begin
         case (state_r)
            HVR_RAMP: begin
               if (sec_tick_i) begin
                  sec_cnt_r <= step_due ? 8'h00 : sec_cnt_r + 8'h01;
               end
               if (step_due) begin
                  current_setpoint_r <= next_set;
                  if (next_set == requested_level_r) begin
                     state_r <= HVR_HOLD;
                  end
               end
            end
            HVR_HOLD: begin
               sec_cnt_r <= 8'h00;
            end
            default: begin
               sec_cnt_r <= 8'h00;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output level; limit is applied every cycle, outside the ramp
   assign limited = sensor_limit_enable_r & ~dark_i &
                    (current_setpoint_r > safe_limit_level_r);
   assign applied = limited ? safe_limit_level_r : current_setpoint_r;

   hvr_supply_drv u_sup_a (
      .mclk_i   (mclk_i),
      .nrst_i   (nrst_i),
      .sel_i    (sup_sel_r[0]),
      .lv_on_i  (low_voltage_supply_on_i[0]),
      .active_i (state_r != HVR_OFF),
      .level_i  (applied),
      .sup_o    (supply_a_o)
   );

   hvr_supply_drv u_sup_b (
      .mclk_i   (mclk_i),
      .nrst_i   (nrst_i),
      .sel_i    (sup_sel_r[1]),
      .lv_on_i  (low_voltage_supply_on_i[1]),
      .active_i (state_r != HVR_OFF),
      .level_i  (applied),
      .sup_o    (supply_b_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: sticky, cleared by a read; a new event beats the clear
   assign reached = (state_r == HVR_RAMP) & step_due & ~turn_off &
                    ~(on_req & on_ok) & (next_set == requested_level_r);
   assign ev[IRQ_REJECT_BIT]  = on_req & ~on_ok & ~turn_off;
   assign ev[IRQ_REACHED_BIT] = reached;
   assign ev[IRQ_TRIPOFF_BIT] = safety_trip_i & (state_r != HVR_OFF);

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         irq_stat_r <= '0;
      end else if (rd_acc && avs_address_i == OFS_IRQSTAT) begin
         irq_stat_r <= ev;
      end else begin
         irq_stat_r <= irq_stat_r | ev;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |((irq_stat_r | ev) & ~irq_mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_over_max_reject: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (on_req && !turn_off && target > max_allowed_level_r)
      |=> $stable(requested_level_r))
      else $error("turn-on above maximum changed the request");

   a_safe_state_block: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (state_r == HVR_OFF && safe_state_i) |=> state_r == HVR_OFF)
      else $error("turn-on accepted in safe state");

   a_safety_cond_block: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (state_r == HVR_OFF && (safety_cond_i & ~safety_mask_r) != '0)
      |=> state_r == HVR_OFF)
      else $error("turn-on accepted with active safety condition");

   a_off_wins: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      turn_off |=> state_r == HVR_OFF && current_setpoint_r == '0
                   ##1 !supply_a_o.on && !supply_b_o.on)
      else $error("turn-off did not take effect");

   a_decrease_at_once: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (on_req && on_ok && !turn_off && target < current_setpoint_r)
      |=> current_setpoint_r == $past(target))
      else $error("decrease was not immediate");

   a_step_no_overshoot: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      state_r != HVR_OFF |-> current_setpoint_r <= requested_level_r)
      else $error("set-point passed the request");

   a_ramp_on_tick: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (state_r == HVR_RAMP && !sec_tick_i && !turn_off && !on_req)
      |=> $stable(current_setpoint_r))
      else $error("set-point moved between intervals");

   a_same_level: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (supply_a_o.on && supply_b_o.on) |-> supply_a_o.level == supply_b_o.level)
      else $error("supplies driven to different levels");

   a_lv_gate: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      !low_voltage_supply_on_i[0] |=> !supply_a_o.on && !supply_a_o.arm)
      else $error("supply on without low-voltage supply");

   a_sensor_limit: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (sensor_limit_enable_r && !dark_i && sup_sel_r[0] && low_voltage_supply_on_i[0])
      |=> supply_a_o.level <= $past(safe_limit_level_r))
      else $error("level above safe limit without dark");

   a_cmd_state_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (state_r == HVR_OFF && !state_a_i && !auto_on_i) |=> state_r == HVR_OFF)
      else $error("direct command accepted outside state_a");

endmodule

// file: hdl/hvr_pkg.sv
// Shared constants and types for the high-voltage ramp controller
package hvr_pkg;

   localparam int LVL_W = 12;
   localparam int FRAC_SCALE_SH = 4;
   localparam logic [7:0] FRAC_LINEAR_LIM = 8'h10;
   localparam int SAFE_W = 8;
   localparam int NUM_SUP = 2;

   // Register byte offsets
   localparam logic [5:0] OFS_CTRL     = 6'h00;
   localparam logic [5:0] OFS_CMDLVL   = 6'h04;
   localparam logic [5:0] OFS_DEFLVL   = 6'h08;
   localparam logic [5:0] OFS_MAXLVL   = 6'h0c;
   localparam logic [5:0] OFS_INTERVAL = 6'h10;
   localparam logic [5:0] OFS_FRAC     = 6'h14;
   localparam logic [5:0] OFS_CONFIG   = 6'h18;
   localparam logic [5:0] OFS_SAFELVL  = 6'h1c;
   localparam logic [5:0] OFS_SMASK    = 6'h20;
   localparam logic [5:0] OFS_STATUS   = 6'h24;
   localparam logic [5:0] OFS_IRQSTAT  = 6'h28;
   localparam logic [5:0] OFS_IRQMASK  = 6'h2c;

   // Field positions
   localparam int CTRL_ON_BIT      = 0;
   localparam int CTRL_OFF_BIT     = 1;
   localparam int CMDLVL_USE_BIT   = 16;
   localparam int CFG_SUP_LSB      = 0;
   localparam int CFG_SENSOR_BIT   = 2;
   localparam int STAT_ACTIVE_BIT  = 0;
   localparam int STAT_RAMP_BIT    = 1;
   localparam int STAT_LIMIT_BIT   = 2;
   localparam int STAT_SET_LSB     = 4;
   localparam int STAT_REQ_LSB     = 16;
   localparam int IRQ_W            = 3;
   localparam int IRQ_REJECT_BIT   = 0;
   localparam int IRQ_REACHED_BIT  = 1;
   localparam int IRQ_TRIPOFF_BIT  = 2;

   // Reset values
   localparam logic [LVL_W-1:0] RST_DEFLVL   = 12'h000;
   localparam logic [LVL_W-1:0] RST_MAXLVL   = 12'h000;
   localparam logic [LVL_W-1:0] RST_SAFELVL  = 12'h000;
   localparam logic [7:0]       RST_INTERVAL = 8'h01;
   localparam logic [7:0]       RST_FRAC     = 8'h01;
   localparam logic [1:0]       RST_SUP_EN   = 2'h3;
   localparam logic [SAFE_W-1:0] RST_SMASK   = 8'h00;

   typedef struct packed {
      logic [LVL_W-1:0] level;
      logic             on;
      logic             arm;
   } hvr_supply_t;

   typedef enum logic [1:0] {
      HVR_OFF   = 2'b00,
      HVR_RAMP  = 2'b01,
      HVR_HOLD  = 2'b10
   } hvr_state_t;

endpackage

// file: hdl/hvr_step_calc.sv
// Ramp step computation with clamp at the requested level
`timescale 1ns/100ps
module hvr_step_calc
   import hvr_pkg::*;
(
   // Levels
   input  wire logic [LVL_W-1:0] req_i,
   input  wire logic [LVL_W-1:0] set_i,
   input  wire logic [7:0]       frac_i,
   // Result
   output logic      [LVL_W-1:0] next_o
);

   logic [LVL_W+FRAC_SCALE_SH-1:0] diff_sc;
   logic [LVL_W+FRAC_SCALE_SH-1:0] quot;
   logic [LVL_W:0]                 sum;
   logic [LVL_W-1:0]               step;

   always_comb begin
      diff_sc = {{FRAC_SCALE_SH{1'b0}}, req_i - set_i} << FRAC_SCALE_SH;
      quot    = '0;
      if (frac_i < FRAC_LINEAR_LIM) begin
         step = {{(LVL_W-8){1'b0}}, frac_i};
      end else begin
         quot = diff_sc / {{(LVL_W+FRAC_SCALE_SH-8){1'b0}}, frac_i};
         step = (quot[LVL_W+FRAC_SCALE_SH-1:LVL_W] != '0) ? '1 : quot[LVL_W-1:0];
         if (step == '0) begin
            step = {{(LVL_W-1){1'b0}}, 1'b1};
         end
      end
      sum = {1'b0, set_i} + {1'b0, step};
      // Never carry past the requested level
      next_o = (sum > {1'b0, req_i}) ? req_i : sum[LVL_W-1:0];
   end

endmodule

// file: hdl/hvr_supply_drv.sv
// Registered drive of one supply: level, enable and arm
`timescale 1ns/100ps
module hvr_supply_drv
   import hvr_pkg::*;
(
   // Clock and reset
   input  wire logic             mclk_i,
   input  wire logic             nrst_i,
   // Control
   input  wire logic             sel_i,
   input  wire logic             lv_on_i,
   input  wire logic             active_i,
   input  wire logic [LVL_W-1:0] level_i,
   // Supply
   output hvr_supply_t           sup_o
);

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         sup_o <= '0;
      end else begin
         sup_o.arm   <= sel_i & lv_on_i & active_i;
         sup_o.on    <= sel_i & lv_on_i & active_i;
         sup_o.level <= (sel_i & lv_on_i & active_i) ? level_i : '0;
      end
   end

endmodule

// file: verification/hvr_far_model.sv
// Far-side model: second tick source and low-voltage supply status
`timescale 1ns/100ps
module hvr_far_model
   import hvr_pkg::*;
#(
   parameter int TICK_DIV = 8
)
(
   // Clock and reset
   input  wire logic       mclk_i,
   input  wire logic       nrst_i,
   // Bench control
   input  wire logic [1:0] lv_en_i,
   // To controller
   output logic            sec_tick_o,
   output logic [1:0]      lv_on_o
);
   logic [7:0] cnt_r;
   // Short tick period so that ramps fit in a short run
   always_ff @(posedge mclk_i) begin
      if (!nrst_i || cnt_r == 8'(TICK_DIV - 1)) begin
         cnt_r <= 8'h00;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end
   assign sec_tick_o = nrst_i && (cnt_r == 8'(TICK_DIV - 1));
   assign lv_on_o    = lv_en_i;
endmodule

// file: verification/test_hvr_ctrl.sv
// Self-checking bench for the high-voltage ramp controller
`timescale 1ns/100ps
module test_hvr_ctrl
   import hvr_pkg::*;
;
   logic             mclk_i, nrst_i, rd, wr, wreq, tick, safe, sta, irq;
   logic             dark;
   logic [3:0]       be;
   logic [2:0]       kick_r;
   logic [5:0]       adr;
   logic [31:0]      wd, rdat, lfsr;
   logic [7:0]       cond;
   logic [1:0]       lv_en, lv_on;
   hvr_supply_t      sa, sb;
   logic [31:0]      rd_q[$];
   logic [LVL_W-1:0] lv_q[$];
   logic [LVL_W-1:0] prev;
   int               err_count, compares, cyc;

   hvr_ctrl DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .sec_tick_i(tick),
      .safe_state_i(safe), .state_a_i(sta), .auto_on_i(kick_r[0]), .auto_off_i(kick_r[1]),
      .safety_cond_i(cond), .safety_trip_i(kick_r[2]), .dark_i(dark),
      .low_voltage_supply_on_i(lv_on), .supply_a_o(sa), .supply_b_o(sb), .irq_o(irq));
   hvr_far_model far (.mclk_i(mclk_i), .nrst_i(nrst_i), .lv_en_i(lv_en),
      .sec_tick_o(tick), .lv_on_o(lv_on));

   ////////////////////////////////////////////////////////////////
   initial mclk_i = 1'b0;
   always #10 mclk_i = ~mclk_i;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic end_sim;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Safety condition bit 0 always active, the others random; only the mask decides
   always @(posedge mclk_i) begin
      lfsr <= lfsr_next(lfsr);
      cond <= lfsr[7:0] | 8'h01;
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
   end

   // Result watchers take the oldest note off each queue
   always @(posedge mclk_i) begin
      if (rd === 1'b1 && wreq === 1'b0 && rd_q.size() > 0) chk(rdat, rd_q.pop_front(), "read");
      if (nrst_i === 1'b1 && sa.level !== prev) begin
         prev = sa.level;
         chk(32'(sa.level), lv_q.size() > 0 ? 32'(lv_q.pop_front()) : 32'hffffffff, "level");
      end
      if (sb.on === 1'b1) chk(32'(sb.level), 32'(sa.level), "same level");
   end

   ////////////////////////////////////////////////////////////////
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      // Waits for waitrequest to drop; only the bench timeout ends a hung wait
      do begin
         @(posedge mclk_i);
      end while (wreq !== 1'b0);
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge mclk_i);
   endtask

   task automatic rdc(input logic [5:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask

   task automatic kick(input logic [2:0] k);
      kick_r <= k;
      @(posedge mclk_i);
      kick_r <= 3'h0;
      repeat (4) @(posedge mclk_i);
   endtask

   task automatic drain;
      int n;
      n = 0;
      while (lv_q.size() > 0 && n < 3000) begin
         @(posedge mclk_i);
         n++;
      end
      repeat (3) @(posedge mclk_i);
      chk(lv_q.size(), 0, "level sequence");
   endtask

   task automatic ramp_exp(input logic [11:0] v, input logic [11:0] t, input logic [7:0] f);
      logic [11:0] s;
      while (v < t) begin
         s = (f < FRAC_LINEAR_LIM) ? 12'(f) : 12'((16'(t - v) << 4) / 16'(f));
         if (s == 12'h000) s = 12'h001;
         v = (t - v < s) ? t : v + s;
         lv_q.push_back(v);
      end
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      {rd, wr, safe, dark, kick_r, adr, wd} = '0;
      {err_count, compares, cyc} = '0;
      sta = 1'b1;
      lv_en = 2'h3;
      be = 4'hf;
      lfsr = 32'hae69;
      prev = '0;
      nrst_i = 1'b0;
      repeat (16) @(posedge mclk_i);
      nrst_i <= 1'b1;
      @(posedge mclk_i);
      chk({sa, sb, irq, wreq}, 32'h1, "reset state");
      bus(1, OFS_SMASK, 32'hff);
      bus(1, OFS_MAXLVL, 32'h100);
      bus(1, OFS_DEFLVL, 32'h22);
      bus(1, OFS_FRAC, 32'h4);
      bus(1, OFS_INTERVAL, 32'h0);
      rdc(OFS_INTERVAL, 32'h1);
      bus(1, OFS_INTERVAL, 32'hff);
      rdc(OFS_INTERVAL, 32'hff);
      bus(1, OFS_INTERVAL, 32'h1);
      ramp_exp(12'h0, 12'h22, 8'h4);
      kick(3'h1);
      drain();
      chk({sa.on, sa.arm, sb.on, sb.arm}, 32'hf, "drive");
      rdc(OFS_IRQSTAT, 32'h2);
      rdc(OFS_STATUS, 32'h00220221);
      bus(1, OFS_CMDLVL, 32'h10200);
      bus(1, OFS_CTRL, 32'h1);
      chk(irq, 1, "irq raised");
      rdc(OFS_IRQSTAT, 32'h1);
      rdc(OFS_STATUS, 32'h00220221);
      // Partial byte lanes must leave the register untouched
      be <= 4'h3;
      bus(1, OFS_DEFLVL, 32'h33);
      be <= 4'hf;
      rdc(OFS_DEFLVL, 32'h22);
      bus(1, OFS_FRAC, 32'h20);
      bus(1, OFS_CMDLVL, 32'h10040);
      ramp_exp(12'h22, 12'h40, 8'h20);
      bus(1, OFS_CTRL, 32'h1);
      drain();
      bus(1, OFS_CMDLVL, 32'h10010);
      lv_q.push_back(12'h10);
      bus(1, OFS_CTRL, 32'h1);
      drain();
      bus(1, OFS_SAFELVL, 32'h8);
      lv_q.push_back(12'h8);
      bus(1, OFS_CONFIG, 32'h7);
      drain();
      lv_q.push_back(12'h10);
      dark <= 1'b1;
      drain();
      bus(1, OFS_CONFIG, 32'h3);
      sta <= 1'b0;
      bus(1, OFS_CTRL, 32'h2);
      chk(sa.on, 1, "off outside state_a");
      sta <= 1'b1;
      lv_q.push_back(12'h0);
      kick(3'h5);
      drain();
      chk(sa.on, 0, "tripped off");
      bus(0, OFS_IRQSTAT, 32'h0);
      bus(1, OFS_IRQMASK, 32'h7);
      safe <= 1'b1;
      kick(3'h1);
      safe <= 1'b0;
      bus(1, OFS_SMASK, 32'hfe);
      kick(3'h1);
      bus(1, OFS_SMASK, 32'hff);
      lv_en <= 2'h0;
      kick(3'h1);
      bus(1, OFS_CONFIG, 32'h1);
      lv_en <= 2'h2;
      kick(3'h1);
      chk({sa.on, irq}, 0, "refused, masked irq");
      rdc(OFS_IRQSTAT, 32'h1);
      bus(1, OFS_IRQMASK, 32'h0);
      lv_en <= 2'h3;
      ramp_exp(12'h0, 12'h22, 8'h20);
      kick(3'h1);
      drain();
      chk({sa.on, sb.on}, 32'h2, "only first on");
      lv_q.push_back(12'h0);
      kick(3'h2);
      drain();
      end_sim();
   end
endmodule
